/* src/rpsc_pkg.sv */
// Package with register map, field positions and power state encodings.
package rpsc_pkg;
    localparam logic [3:0] ADDR_CTRL      = 4'h9;
    localparam logic [3:0] ADDR_STATUS    = 4'hA;
    localparam int         CTRL_PD_BIT    = 3;
    localparam int         CTRL_RETIME_BIT = 0;
    localparam logic [7:0] CTRL_RESET_VAL = 8'h01;
    localparam logic [7:0] READ_UNMAPPED  = 8'h00;

    typedef enum logic [3:0] {
        RPSC_PD_PIN   = 4'b0001,
        RPSC_PD_HPD   = 4'b0010,
        RPSC_PD_SOFT  = 4'b0100,
        RPSC_STANDBY  = 4'b1000
    } rpsc_pd_t;

    typedef enum logic [2:0] {
        RPSC_ST_OFF     = 3'b001,
        RPSC_ST_STANDBY = 3'b010,
        RPSC_ST_NORMAL  = 3'b100
    } rpsc_state_t;
endpackage : rpsc_pkg

/* src/rpsc_sync.sv */
// Two flip-flop synchroniser for one level input.
`timescale 1ns/1ns
module rpsc_sync (
    input  wire logic mclk_in,
    input  wire logic rst_in,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_next;

    always_comb
    begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_out <= sync_next;
        end
    end
endmodule : rpsc_sync

/* src/rpsc_top.sv */
// Power-state controller for a video retimer with Avalon-MM control registers.
// Behaviour
// R1: Chip-activate low: everything off, outputs high-Z, receive termination kept on.
// R2: Chip-activate rising edge resets all programmable settings to defaults.
// R3: Host must rewrite its settings after every chip-activate reset.
// R4: Power-down bit in control register forces power-down regardless of pins.
// R5: Soft power-down with hot-plug high keeps control port and hot-plug out active.
// R6: Activate high, hot-plug low: power-down, control port active, outputs high-Z.
// R7: Hot-plug high without valid clock: standby, clock lane only, side channels on; the code enters standby this way only in retimer mode.
// R8: Normal mode runs as redriver, or as retimer only with a valid clock.
// R9: With hot-plug high, outputs enable only from the clock detector result; the code uses the detector only in retimer mode.
// R10: Source hot-plug output follows sink hot-plug input at all times.
// R11: Chip-activate and sink hot-plug are synchronised before selecting state.
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module rpsc_top (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       chip_activate_in,
    input  wire logic       hotplug_from_sink_in,
    input  wire logic       clock_valid_in,
    input  wire logic       signal_detect_enable_in,
    input  wire logic [3:0] avs_address_in,
    input  wire logic       avs_read_in,
    input  wire logic       avs_write_in,
    input  wire logic [7:0] avs_writedata_in,
    output logic [7:0]      avs_readdata_out,
    output logic            avs_waitrequest_out,
    output logic            hotplug_to_source_out,
    output logic            rx_termination_out,
    output logic [2:0]      data_lane_inputs_en_out,
    output logic            clock_lane_rx_en_out,
    output logic            data_lane_outputs_en_out,
    output logic            cdr_en_out,
    output logic            ddc_en_out,
    output logic            audio_return_path_en_out,
    output logic            local_control_port_en_out
);
    logic act_sync;
    logic hpd_sync;
    logic clk_sync;
    logic act_prev_reg;
    logic act_prev_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    rpsc_pkg::rpsc_state_t state_reg;
    rpsc_pkg::rpsc_state_t state_next;
    logic act_rise;
    logic soft_pd;
    logic retime;
    logic ctrl_on;
    logic hpd_out_reg;
    logic cdr_reg;
    logic cdr_next;

    // Pin inputs cross into the clock domain before any decision uses them.
    rpsc_sync u_sync_act (.mclk_in(mclk_in), .rst_in(rst_in),
        .async_in(chip_activate_in), .sync_out(act_sync)); // [R11]
    rpsc_sync u_sync_hpd (.mclk_in(mclk_in), .rst_in(rst_in),
        .async_in(hotplug_from_sink_in), .sync_out(hpd_sync)); // [R11]
    rpsc_sync u_sync_clk (.mclk_in(mclk_in), .rst_in(rst_in),
        .async_in(clock_valid_in), .sync_out(clk_sync));

    assign act_rise = act_sync & ~act_prev_reg; // [R2]
    assign soft_pd  = ctrl_reg[rpsc_pkg::CTRL_PD_BIT];
    assign retime   = ctrl_reg[rpsc_pkg::CTRL_RETIME_BIT];

    // The register file is held in reset while activate is low so that no stale
    // setting survives; the host reprograms after the rising edge.
    always_comb
    begin
        act_prev_next = act_sync;
        ctrl_next     = ctrl_reg;
        rdata_next    = rpsc_pkg::READ_UNMAPPED;
        ack_next      = 1'b0;
        // A write lands on the edge that completes the transfer, when waitrequest is low.
        if (avs_write_in && ack_reg && avs_address_in == rpsc_pkg::ADDR_CTRL)
        begin
            ctrl_next = avs_writedata_in; // [R4]
        end
        if ((avs_read_in || avs_write_in) && !ack_reg)
        begin
            ack_next = 1'b1;
            if (avs_read_in && avs_address_in == rpsc_pkg::ADDR_CTRL)
            begin
                rdata_next = ctrl_reg;
            end
            else if (avs_read_in && avs_address_in == rpsc_pkg::ADDR_STATUS)
            begin
                rdata_next = {3'h0, hpd_sync, act_sync, state_reg};
            end
        end
        if (act_rise || !act_sync)
        begin
            ctrl_next = rpsc_pkg::CTRL_RESET_VAL; // [R2]
        end
    end

    // In retimer mode the clock detector result decides standby versus normal once hot-plug is high.
    always_comb
    begin
        case (state_reg)
            rpsc_pkg::RPSC_ST_OFF,
            rpsc_pkg::RPSC_ST_STANDBY,
            rpsc_pkg::RPSC_ST_NORMAL:
            begin
                if (!act_sync || !hpd_sync || soft_pd)
                begin
                    state_next = rpsc_pkg::RPSC_ST_OFF; // [R1] [R4] [R6]
                end
                else if (retime && !clk_sync)
                begin
                    state_next = rpsc_pkg::RPSC_ST_STANDBY; // [R7] [R9]
                end
                else
                begin
                    state_next = rpsc_pkg::RPSC_ST_NORMAL; // [R8] [R9]
                end
            end
            default:
            begin
                state_next = rpsc_pkg::RPSC_ST_OFF;
            end
        endcase
        // Registered with the state so that a mode write cannot start recovery unclocked.
        cdr_next = (state_next == rpsc_pkg::RPSC_ST_NORMAL) && retime && clk_sync; // [R8] [R9]
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            act_prev_reg <= 1'b0;
            ctrl_reg     <= rpsc_pkg::CTRL_RESET_VAL;
            rdata_reg    <= rpsc_pkg::READ_UNMAPPED;
            ack_reg      <= 1'b0;
            state_reg    <= rpsc_pkg::RPSC_ST_OFF;
            cdr_reg      <= 1'b0;
            hpd_out_reg  <= 1'b0;
        end
        else
        begin
            act_prev_reg <= act_prev_next;
            ctrl_reg     <= ctrl_next;
            rdata_reg    <= rdata_next;
            ack_reg      <= ack_next;
            state_reg    <= state_next;
            cdr_reg      <= cdr_next;
            hpd_out_reg  <= hpd_sync; // [R10]
        end
    end

    assign ctrl_on                   = act_sync;
    assign avs_waitrequest_out       = (avs_read_in || avs_write_in) && !ack_reg;
    assign avs_readdata_out          = rdata_reg;
    assign hotplug_to_source_out     = hpd_out_reg; // [R10] [R5]
    assign rx_termination_out        = 1'b1; // [R1]
    assign data_lane_inputs_en_out   = {3{state_reg == rpsc_pkg::RPSC_ST_NORMAL}}; // [R7]
    assign clock_lane_rx_en_out      = state_reg != rpsc_pkg::RPSC_ST_OFF; // [R7]
    assign data_lane_outputs_en_out  = state_reg == rpsc_pkg::RPSC_ST_NORMAL; // [R1] [R9]
    assign cdr_en_out                = cdr_reg; // [R8]
    assign ddc_en_out                = state_reg != rpsc_pkg::RPSC_ST_OFF; // [R5]
    assign audio_return_path_en_out  = state_reg != rpsc_pkg::RPSC_ST_OFF; // [R5]
    assign local_control_port_en_out = ctrl_on; // [R1] [R5] [R6]

    property p_off_when_inactive;
        @(posedge mclk_in) disable iff (rst_in)
        !act_sync |=> !data_lane_outputs_en_out && !ddc_en_out;
    endproperty
    a_off_when_inactive: assert property (p_off_when_inactive) // [R1]
        else $error("Outputs active while chip activate low.");

    property p_reset_on_rise;
        @(posedge mclk_in) disable iff (rst_in)
        act_rise |=> ctrl_reg == rpsc_pkg::CTRL_RESET_VAL;
    endproperty
    a_reset_on_rise: assert property (p_reset_on_rise) // [R2]
        else $error("Settings not reset after activate rise.");

    property p_soft_pd;
        @(posedge mclk_in) disable iff (rst_in)
        soft_pd |=> state_reg == rpsc_pkg::RPSC_ST_OFF;
    endproperty
    a_soft_pd: assert property (p_soft_pd) // [R4]
        else $error("Soft power-down not honoured.");

    property p_soft_pd_side;
        @(posedge mclk_in) disable iff (rst_in)
        (soft_pd && act_sync && hpd_sync) |-> local_control_port_en_out ##1
            (hotplug_to_source_out && !audio_return_path_en_out && !ddc_en_out &&
            !data_lane_outputs_en_out);
    endproperty
    a_soft_pd_side: assert property (p_soft_pd_side) // [R5]
        else $error("Wrong outputs in soft power-down.");

    property p_no_hpd;
        @(posedge mclk_in) disable iff (rst_in)
        (act_sync && !hpd_sync)[*2] |-> local_control_port_en_out &&
            !data_lane_outputs_en_out;
    endproperty
    a_no_hpd: assert property (p_no_hpd) // [R6]
        else $error("Wrong outputs with sink hot-plug low.");

    property p_standby;
        @(posedge mclk_in) disable iff (rst_in)
        state_reg == rpsc_pkg::RPSC_ST_STANDBY |-> clock_lane_rx_en_out &&
            data_lane_inputs_en_out == 3'h0 && ddc_en_out && !data_lane_outputs_en_out;
    endproperty
    a_standby: assert property (p_standby) // [R7]
        else $error("Standby outputs wrong.");

    property p_retime_needs_clock;
        @(posedge mclk_in) disable iff (rst_in)
        cdr_en_out |-> state_reg == rpsc_pkg::RPSC_ST_NORMAL && $past(clk_sync);
    endproperty
    a_retime_needs_clock: assert property (p_retime_needs_clock) // [R8] [R9]
        else $error("Retimer active without valid clock.");

    property p_hpd_follow;
        @(posedge mclk_in) disable iff (rst_in)
        hpd_sync |=> hotplug_to_source_out == $past(hpd_sync);
    endproperty
    a_hpd_follow: assert property (p_hpd_follow) // [R10]
        else $error("Source hot-plug does not follow sink.");

    c_normal:  cover property (@(posedge mclk_in) state_reg == rpsc_pkg::RPSC_ST_NORMAL);
    c_standby: cover property (@(posedge mclk_in) state_reg == rpsc_pkg::RPSC_ST_STANDBY);
    c_soft:    cover property (@(posedge mclk_in) soft_pd && act_sync && hpd_sync);
    c_rise:    cover property (@(posedge mclk_in) act_rise);
endmodule : rpsc_top

/* dv/rpsc_link_model.sv */
// Far-side model: sink hot-plug level and a clock-lane detector that needs time to lock.
`timescale 1ns/1ns
module rpsc_link_model #(
    parameter int LAG = 4
) (
    input  wire logic mclk_in,
    input  wire logic plug_in,
    input  wire logic clock_on_in,
    output logic      hotplug_from_sink_out,
    output logic      clock_valid_out
);
    int cnt = 0;

    assign hotplug_from_sink_out = plug_in;

    // A clock is reported only after the source has driven it for LAG cycles.
    // A larger LAG gives a slower detector.
    always @(posedge mclk_in)
        cnt <= (plug_in && clock_on_in) ? ((cnt < LAG) ? cnt + 1 : cnt) : 0;

    assign clock_valid_out = (cnt == LAG);
endmodule : rpsc_link_model

/* dv/tb_top.sv */
// Testbench comparing the power-state controller with a behavioural model.
`timescale 1ns/1ns
module tb_top;
    logic       mclk = 0, rst = 1, ca = 0, plug = 0, clk_on = 0, sde = 0, rd = 0, wr = 0;
    logic       hpd, cv, wrq, hpo, term, crx, oen, cdr, ddc, audio_return_path, lcp;
    logic [3:0] adr = 4'h0;
    logic [7:0] wd = 8'h00, rdata, q;
    logic [2:0] lanes;
    int         n_errors = 0, n_checks = 0, ctl = 1, r;

    always #25 mclk = ~mclk;

    rpsc_link_model #(.LAG(4)) i_rpsc_link_model (.mclk_in(mclk), .plug_in(plug),
        .clock_on_in(clk_on), .hotplug_from_sink_out(hpd), .clock_valid_out(cv));

    rpsc_top i_rpsc_top (.mclk_in(mclk), .rst_in(rst), .chip_activate_in(ca),
        .hotplug_from_sink_in(hpd), .clock_valid_in(cv), .signal_detect_enable_in(sde),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wrq), .hotplug_to_source_out(hpo),
        .rx_termination_out(term), .data_lane_inputs_en_out(lanes),
        .clock_lane_rx_en_out(crx), .data_lane_outputs_en_out(oen), .cdr_en_out(cdr),
        .ddc_en_out(ddc), .audio_return_path_en_out(audio_return_path), .local_control_port_en_out(lcp));

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One Avalon transfer; the request holds until waitrequest is sampled low at a rising
    // edge, read data is taken at that edge, and only then is the request released.
    // Values read right after the edge are those the design sampled on it.
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        adr <= a;
        wr  <= w;
        rd  <= !w;
        wd  <= d;
        @(posedge mclk);
        while (wrq !== 1'b0)
        begin
            @(posedge mclk);
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : acc

    // Expected status byte and output enables: 0 off, 1 standby, 2 normal.
    function automatic logic [18:0] model();
        int st;
        st = (!ca || !plug || ctl[3]) ? 0 : (ctl[0] && !clk_on) ? 1 : 2;
        return {3'b000, plug, ca, 3'(3'b001 << st), plug, 1'b1, {3{st == 2}}, st != 0,
                st == 2, st == 2 && ctl[0], st != 0, st != 0, ca};
    endfunction : model

    initial
    begin
        #(50 * 20000);
        n_errors++;
        end_of_test();
    end

    initial
    begin
        r = $urandom(69423);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 60; i++)
        begin
            r = $urandom;
            ca <= r[0] | (i < 3);
            plug <= r[1] | r[7];
            clk_on <= r[2];
            sde <= r[3];
            repeat (6) @(posedge mclk);
            if (!ca)
                ctl = 1;
            else if (r[4])
            begin
                ctl = {r[5], 2'b00, r[6]};
                acc(1'b1, 4'h9, 8'(ctl));
            end
            repeat (6) @(posedge mclk);
            acc(1'b0, 4'hA, 8'h00);
            check({1'b0, q, hpo, term, lanes, crx, oen, cdr, ddc, audio_return_path, lcp}, {1'b0, model()});
            acc(1'b0, 4'h9, 8'h00);
            check({12'h000, q}, 20'(ctl));
            acc(1'b1, 4'h5, 8'hFF);
            acc(1'b0, 4'h5, 8'h00);
            check({12'h000, q}, 20'h0_0000);
        end
        end_of_test();
    end
endmodule : tb_top
